// ===== src/smcp_pkg.sv
// Function
// - Motion commands fall into a run group that holds a speed and a move group that covers a displacement.
// - Every write of one to the launch coil starts the set motion, even if never cleared, and a write of zero does nothing.
// - A halt or high-impedance command in the same cycle as a launch wins and the launch is dropped.
// - The 32-bit speed register in pulses per second is the target speed for run and the top speed for move.
// - With full-step switching off, speed is held between 8 and 120000 pulses per second.
// - With full-step switching on, the top limit is 120000 times two to the power of the microstep setting, with settings above 8 treated as 8.
// - The 32-bit floor rate register is the lowest speed for run, and for move only while automatic floor is off.
// - With automatic floor on, move commands use a fixed floor rate of 8 pulses per second.
// - The acceleration rate comes from a 16-bit register.
// - The deceleration rate comes from a 16-bit register.
// - The 32-bit position register reports position in microsteps.
// - Parameters and commands are readable and writable over the register port only in run mode.
package smcp_pkg;
    localparam logic [15:0] ADDR_TARGET_RATE = 16'h5000;
    localparam logic [15:0] ADDR_FLOOR_RATE = 16'h5002;
    localparam logic [15:0] ADDR_RAMP_UP = 16'h5004;
    localparam logic [15:0] ADDR_RAMP_DOWN = 16'h5005;
    localparam logic [15:0] ADDR_POSITION = 16'h5006;
    localparam logic [15:0] ADDR_LAUNCH_COIL = 16'h5100;
    localparam logic [31:0] RATE_MIN = 32'h0000_0008;
    localparam logic [31:0] RATE_MAX = 32'h0001_D4C0;
    localparam logic [3:0] USTEP_MAX_SHIFT = 4'h8;
    localparam logic [31:0] TARGET_RATE_RST = 32'h0000_0008;
    localparam logic [31:0] FLOOR_RATE_RST = 32'h0000_0008;
    localparam logic [15:0] RAMP_RST = 16'h0000;
    localparam logic [31:0] POSITION_RST = 32'h0000_0000;
    localparam logic [31:0] AUTO_FLOOR_RATE = 32'h0000_0008;
    typedef enum logic [1:0] {
        SMCP_GROUP_RUN = 2'b00,
        SMCP_GROUP_MOVE = 2'b01
    } smcp_group_e;
endpackage

// ===== src/smcp_rate_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module smcp_rate_clamp (
    input wire logic [31:0] rate_in,
    input wire logic fullstep_switch_enable,
    input wire logic [3:0] microstep_shift,
    output logic [31:0] rate_out
);
    logic [3:0] shift_lim;
    logic [31:0] upper;
    always_comb begin
        shift_lim = (microstep_shift > smcp_pkg::USTEP_MAX_SHIFT) ?
            smcp_pkg::USTEP_MAX_SHIFT : microstep_shift;
        if (fullstep_switch_enable) begin
            upper = smcp_pkg::RATE_MAX << shift_lim;
        end else begin
            upper = smcp_pkg::RATE_MAX;
        end
        if (rate_in < smcp_pkg::RATE_MIN) begin
            rate_out = smcp_pkg::RATE_MIN;
        end else if (rate_in > upper) begin
            rate_out = upper;
        end else begin
            rate_out = rate_in;
        end
    end
endmodule
`default_nettype wire

// ===== src/smcp_front.sv
`timescale 1ns/1ps
`default_nettype none
module smcp_front (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire logic move_group_sel,
    input wire logic fullstep_switch_enable,
    input wire logic auto_floor_rate_enable,
    input wire logic [3:0] microstep_shift,
    input wire logic halt_commands,
    input wire logic high_impedance_commands,
    input wire logic position_load,
    input wire logic [31:0] position_in,
    output logic start_pulse,
    output logic move_group,
    output logic [31:0] speed_limit,
    output logic [31:0] floor_limit,
    output logic [15:0] accel,
    output logic [15:0] decel,
    output logic [31:0] position
);
    logic [31:0] target_rate_reg;
    logic [31:0] floor_rate_reg;
    logic [15:0] ramp_up_rate_reg;
    logic [15:0] ramp_down_rate_reg;
    logic [31:0] current_position_reg;
    logic [31:0] clamped;
    logic [31:0] speed_limit_next;
    logic [31:0] floor_limit_next;
    logic wr_ok;
    logic rd_ok;
    logic launch_req;
    smcp_pkg::smcp_group_e group_reg;

    ////////////////////////////////////////////////////////////////////////
    assign wr_ok = reg_wr & run_mode;
    assign rd_ok = reg_rd & run_mode;
    // zero written to the coil is dropped, repeated ones each launch
    assign launch_req = wr_ok & (reg_addr == smcp_pkg::ADDR_LAUNCH_COIL)
        & reg_wdata[0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            target_rate_reg <= smcp_pkg::TARGET_RATE_RST;
            floor_rate_reg <= smcp_pkg::FLOOR_RATE_RST;
            ramp_up_rate_reg <= smcp_pkg::RAMP_RST;
            ramp_down_rate_reg <= smcp_pkg::RAMP_RST;
        end else if (wr_ok) begin
            case (reg_addr)
                smcp_pkg::ADDR_TARGET_RATE: begin
                    target_rate_reg <= reg_wdata;
                end
                smcp_pkg::ADDR_FLOOR_RATE: begin
                    floor_rate_reg <= reg_wdata;
                end
                smcp_pkg::ADDR_RAMP_UP: begin
                    ramp_up_rate_reg <= reg_wdata[15:0];
                end
                smcp_pkg::ADDR_RAMP_DOWN: begin
                    ramp_down_rate_reg <= reg_wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // a write from the bus beats the generator's update in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            current_position_reg <= smcp_pkg::POSITION_RST;
        end else if (wr_ok && reg_addr == smcp_pkg::ADDR_POSITION) begin
            current_position_reg <= reg_wdata;
        end else if (position_load) begin
            current_position_reg <= position_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= wr_ok | rd_ok;
            if (rd_ok) begin
                case (reg_addr)
                    smcp_pkg::ADDR_TARGET_RATE: begin
                        reg_rdata <= target_rate_reg;
                    end
                    smcp_pkg::ADDR_FLOOR_RATE: begin
                        reg_rdata <= floor_rate_reg;
                    end
                    smcp_pkg::ADDR_RAMP_UP: begin
                        reg_rdata <= {16'h0000, ramp_up_rate_reg};
                    end
                    smcp_pkg::ADDR_RAMP_DOWN: begin
                        reg_rdata <= {16'h0000, ramp_down_rate_reg};
                    end
                    smcp_pkg::ADDR_POSITION: begin
                        reg_rdata <= current_position_reg;
                    end
                    default: begin
                        reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    smcp_rate_clamp u_clamp (
        .rate_in(target_rate_reg),
        .fullstep_switch_enable(fullstep_switch_enable),
        .microstep_shift(microstep_shift),
        .rate_out(clamped)
    );

    always_comb begin
        speed_limit_next = clamped;
        if (move_group_sel && auto_floor_rate_enable) begin
            floor_limit_next = smcp_pkg::AUTO_FLOOR_RATE;
        end else begin
            floor_limit_next = floor_rate_reg;
        end
    end

    // parameters are latched at launch so later writes can't disturb a motion
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_pulse <= 1'b0;
            group_reg <= smcp_pkg::SMCP_GROUP_RUN;
            speed_limit <= smcp_pkg::TARGET_RATE_RST;
            floor_limit <= smcp_pkg::FLOOR_RATE_RST;
            accel <= smcp_pkg::RAMP_RST;
            decel <= smcp_pkg::RAMP_RST;
        end else begin
            start_pulse <= launch_req & ~halt_commands
                & ~high_impedance_commands;
            if (launch_req && !halt_commands && !high_impedance_commands) begin
                group_reg <= move_group_sel ? smcp_pkg::SMCP_GROUP_MOVE :
                    smcp_pkg::SMCP_GROUP_RUN;
                speed_limit <= speed_limit_next;
                floor_limit <= floor_limit_next;
                accel <= ramp_up_rate_reg;
                decel <= ramp_down_rate_reg;
            end
        end
    end

    assign move_group = (group_reg == smcp_pkg::SMCP_GROUP_MOVE);
    assign position = current_position_reg;
endmodule
`default_nettype wire

// ===== verification/smcp_front_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module smcp_front_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run_mode,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic move_group_sel,
    input wire logic auto_floor_rate_enable,
    input wire logic halt_commands,
    input wire logic high_impedance_commands,
    input wire logic start_pulse,
    input wire logic move_group,
    input wire logic [31:0] speed_limit,
    input wire logic [31:0] floor_limit
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic acc, go;
    assign acc = (reg_wr || reg_rd) && run_mode;
    assign go = acc && reg_wr && reg_addr == smcp_pkg::ADDR_LAUNCH_COIL
        && reg_wdata[0] && !halt_commands && !high_impedance_commands;
    sequence s_launch; go ##1 start_pulse; endsequence
    a_access_ack: assert property (acc |=> reg_ack)
        else $error("access not acked");
    a_refused_quiet: assert property (!acc |=> !reg_ack)
        else $error("ack without access");
    a_launch_pulse: assert property (go |-> s_launch)
        else $error("launch gave no pulse");
    a_pulse_cause: assert property (start_pulse |-> $past(go))
        else $error("pulse without clean launch");
    a_group_latch: assert property (
        go |=> move_group == $past(move_group_sel))
        else $error("group not latched");
    a_limit_hold: assert property (
        !start_pulse |-> $stable(speed_limit))
        else $error("limit moved without launch");
    a_speed_floor: assert property (
        start_pulse |-> speed_limit >= smcp_pkg::RATE_MIN)
        else $error("speed below minimum");
    a_auto_floor: assert property (
        go && auto_floor_rate_enable && move_group_sel
        |=> floor_limit == smcp_pkg::AUTO_FLOOR_RATE)
        else $error("auto floor not used");
endmodule
bind smcp_front smcp_front_assertions chk (.*);
`default_nettype wire

// ===== verification/smcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smcp_host_model (
    input wire logic clk,
    input wire logic reg_ack,
    input wire logic [31:0] reg_rdata,
    output logic run_mode,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata
);
    logic ack_seen;
    logic [31:0] rd_seen;
    initial begin
        run_mode = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0000_0000;
    end
    // caller loads parameters before the coil write
    task automatic access(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a; // released bus must not show stale values
        reg_wdata <= ~d;
        #1;
        ack_seen = reg_ack;
        rd_seen = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_stepper_motion_command_params.sv
`timescale 1ns/1ps
`default_nettype none
module tb_stepper_motion_command_params;
    logic clk = 1'b0, sys_rst = 1'b1, run_mode, reg_wr, reg_rd, reg_ack;
    logic move_group_sel = 1'b0, fullstep_switch_enable = 1'b0;
    logic auto_floor_rate_enable = 1'b0, halt_commands = 1'b0;
    logic high_impedance_commands = 1'b0, position_load = 1'b0;
    logic start_pulse, move_group;
    logic [3:0] microstep_shift = 4'h0;
    logic [15:0] reg_addr, accel, decel;
    logic [31:0] reg_wdata, reg_rdata, speed_limit, floor_limit, position;
    logic [31:0] position_in = 32'h0000_0000;
    int failures = 0, comparisons = 0;
    always #10 clk = ~clk;
    smcp_front uut (.*);
    smcp_host_model host (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        host.access(1'b0, a, 32'h0000_0000);
        chk({31'h0, host.ack_seen}, 32'h1);
        chk(host.rd_seen, e);
    endtask
    // host looks for the previous start to be gone before a new launch
    task automatic launch(input logic [31:0] e_spd, input logic e_go);
        @(negedge clk);
        chk({31'h0, start_pulse}, 32'h0);
        host.access(1'b1, 16'h5100, 32'h0000_0001);
        chk({31'h0, start_pulse}, {31'h0, e_go});
        if (e_go) chk(speed_limit, e_spd);
    endtask
    task automatic finish_test;
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(16'h5000, 32'h0000_0008);
        rd(16'h5006, 32'h0000_0000);
        host.access(1'b1, 16'h5000, 32'h0003_0D40);
        host.access(1'b1, 16'h5002, 32'h0000_0064);
        host.access(1'b1, 16'h5004, 32'h1234_0ABC);
        host.access(1'b1, 16'h5005, 32'h0000_0BCD);
        rd(16'h5004, 32'h0000_0ABC);
        rd(16'h7000, 32'h0000_0000);
        launch(32'h0001_D4C0, 1'b1);
        chk(floor_limit, 32'h0000_0064);
        chk({accel, decel}, 32'h0ABC_0BCD);
        @(posedge clk) fullstep_switch_enable <= 1'b1;
        microstep_shift <= 4'h1;
        move_group_sel <= 1'b1;
        auto_floor_rate_enable <= 1'b1;
        launch(32'h0003_0D40, 1'b1);
        chk(floor_limit, 32'h0000_0008);
        chk({31'h0, move_group}, 32'h1);
        host.access(1'b1, 16'h5000, 32'h0000_0003);
        @(posedge clk) halt_commands <= 1'b1;
        launch(32'h0, 1'b0);
        @(posedge clk) halt_commands <= 1'b0;
        high_impedance_commands <= 1'b1;
        launch(32'h0, 1'b0);
        @(posedge clk) high_impedance_commands <= 1'b0;
        auto_floor_rate_enable <= 1'b0;
        launch(32'h0000_0008, 1'b1);
        chk(floor_limit, 32'h0000_0064);
        host.access(1'b1, 16'h5100, 32'h0000_0000);
        chk({31'h0, start_pulse}, 32'h0);
        @(posedge clk) host.run_mode <= 1'b0;
        host.access(1'b1, 16'h5000, 32'h0000_0005);
        chk({31'h0, host.ack_seen}, 32'h0);
        @(posedge clk) host.run_mode <= 1'b1;
        rd(16'h5000, 32'h0000_0003);
        @(posedge clk) position_load <= 1'b1;
        position_in <= 32'h0000_1234;
        @(posedge clk) position_load <= 1'b0;
        rd(16'h5006, 32'h0000_1234);
        chk(position, 32'h0000_1234);
        host.access(1'b1, 16'h5006, 32'h0000_0055);
        rd(16'h5006, 32'h0000_0055);
        chk(position, 32'h0000_0055);
        finish_test;
    end
endmodule
`default_nettype wire
